// [rtl/tsq_conv_dev.sv]
// converter end: control byte receiver, conversion sequencer, switch control
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "tsq_cfg.svh"
module tsq_conv_dev (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  tsq_if.dev               LINK,
  input  wire logic [11:0] SAMPLE_DATA,
  output logic             DRV_X_POS,
  output logic             DRV_X_NEG,
  output logic             DRV_Y_POS,
  output logic             DRV_Y_NEG,
  output tsq_pkg::tsq_chan_t MUX_SEL,
  output logic             REF_DIFF_SEL,
  output logic             SAMPLE_HOLD,
  output logic             TEMP_BIAS_BASE,
  output logic             TEMP_BIAS_X91,
  output logic             BAT_DIV_EN,
  output logic             ADC_POWER_ON,
  output logic             REF_POWER_ON
);
  import tsq_pkg::*;

  // switch pattern {x+, x-, y+, y-} per channel, same in both reference kinds
  function automatic logic [3:0] chan_drv(input tsq_chan_t ch);
    case (ch)
      3'h1:    chan_drv = 4'h3;
      3'h3:    chan_drv = 4'h6;
      3'h4:    chan_drv = 4'h6;
      3'h5:    chan_drv = 4'hC;
      default: chan_drv = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sclk_rise;
  logic sclk_fall;
  logic cs_b_s;
  logic din_s;

  tsq_edge_sync u_sclk (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .ASYNC_IN (LINK.serial_clock_in),
    .LEVEL    (),
    .RISE     (sclk_rise),
    .FALL     (sclk_fall)
  );

  tsq_edge_sync u_cs (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .ASYNC_IN (LINK.cs_b),
    .LEVEL    (cs_b_s),
    .RISE     (),
    .FALL     ()
  );

  tsq_edge_sync u_din (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .ASYNC_IN (LINK.din),
    .LEVEL    (din_s),
    .RISE     (),
    .FALL     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // control byte receiver

  tsq_rx_st_t rx_st_reg;
  tsq_rx_st_t rx_st_next;
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_cnt_next;
  logic [5:0] rx_shift_reg;
  tsq_chan_t  acq_ch_reg;
  tsq_ctl_t   ctl_reg;

  // nothing moves without an edge, so a halted clock freezes everything
  wire take      = sclk_rise & ~cs_b_s;
  wire byte_done = (rx_st_reg == RX_ACQ) & take & (rx_cnt_reg == `TSQ_BYTE_CLKS - 4'h1);
  wire acq       = (rx_st_reg == RX_ACQ);

  // low input while hunting is skipped until a start bit
  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_cnt_next = rx_cnt_reg;
    case (rx_st_reg)
      RX_HUNT: begin
        if (take && din_s) begin
          rx_st_next  = RX_CFG;
          rx_cnt_next = 4'h1;
        end
      end
      RX_CFG: begin
        if (take) begin
          rx_cnt_next = rx_cnt_reg + 4'h1;
          if (rx_cnt_next == `TSQ_ACQ_EDGE) begin
            rx_st_next = RX_ACQ;
          end
        end
      end
      RX_ACQ: begin
        if (take) begin
          rx_cnt_next = rx_cnt_reg + 4'h1;
          if (byte_done) begin
            rx_st_next = RX_HUNT;
          end
        end
      end
      default: rx_st_next = RX_HUNT;
    endcase
    if (cs_b_s) begin
      rx_st_next  = RX_HUNT;
      rx_cnt_next = 4'h0;
    end
  end

  // shift msb first; channel is known after the third channel bit, as the resolution bit comes in
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_st_reg    <= RX_HUNT;
      rx_cnt_reg   <= 4'h0;
      rx_shift_reg <= 6'h00;
      acq_ch_reg   <= 3'h0;
      ctl_reg      <= 7'h00;
    end else begin
      rx_st_reg  <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      if (take && rx_st_reg != RX_HUNT) begin
        rx_shift_reg <= {rx_shift_reg[4:0], din_s};
      end
      if (rx_st_reg == RX_CFG && rx_st_next == RX_ACQ) begin
        acq_ch_reg <= rx_shift_reg[2:0];
      end
      if (byte_done) begin
        ctl_reg <= {rx_shift_reg, din_s};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  tsq_cv_st_t cv_st_reg;
  logic [3:0] cv_cnt_reg;
  logic [11:0] smp_reg;
  logic        dout_reg;
  logic        busy_reg;

  // the receiver runs apart from the sequencer so a new byte can overlap
  wire       conv_on  = (cv_st_reg == CV_RUN);
  wire [3:0] cv_k     = cv_cnt_reg + 4'h1;
  // ratiometric delays the msb by one clock
  wire [3:0] first_k  = ctl_reg.reference_kind_select ? 4'h1 : 4'h2;
  wire [3:0] nbits    = ctl_reg.mode8 ? `TSQ_RES_LO : `TSQ_RES_HI;
  wire [3:0] last_k   = first_k + nbits - 4'h1;
  wire       bit_win  = (cv_k >= first_k) && (cv_k <= last_k);
  wire [3:0] bit_idx  = 4'hB - (cv_k - first_k);
  wire       conv_end = sclk_fall & conv_on & (cv_k == last_k + 4'h1);

  // result bits move on falling edges; outside the window the line is low
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cv_st_reg  <= CV_IDLE;
      cv_cnt_reg <= 4'h0;
      smp_reg    <= 12'h000;
      dout_reg   <= 1'b0;
      busy_reg   <= 1'b0;
    end else if (cs_b_s) begin
      cv_st_reg <= CV_IDLE;
      dout_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else if (byte_done) begin
      cv_st_reg  <= CV_RUN;
      cv_cnt_reg <= 4'h0;
      smp_reg    <= SAMPLE_DATA;
      dout_reg   <= 1'b0;
      busy_reg   <= 1'b1;
    end else if (conv_end) begin
      cv_st_reg <= CV_IDLE;
      dout_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else if (sclk_fall && conv_on) begin
      cv_cnt_reg <= cv_k;
      dout_reg   <= bit_win ? smp_reg[bit_idx] : 1'b0;
    end
  end

  assign LINK.dout    = dout_reg;
  assign LINK.dout_oe = ~cs_b_s;
  assign LINK.busy    = busy_reg;
  assign LINK.busy_oe = ~cs_b_s;

  ////////////////////////////////////////////////////////////////////////////
  // analog switch control

  wire [1:0] pd      = {ctl_reg.power_ctl_bit1, ctl_reg.power_ctl_bit0};
  wire       between = ~acq & ~conv_on;
  wire [2:0] ctl_ch  = {ctl_reg.channel_select_bit2, ctl_reg.channel_select_bit1, ctl_reg.channel_select_bit0};
  wire [3:0] pat     = chan_drv(acq ? acq_ch_reg : ctl_ch);
  // single-ended drops the drivers at hold, ratiometric keeps them
  wire drv_on = acq
              | (conv_on & ~ctl_reg.reference_kind_select)
              | (between & ctl_reg.power_ctl_bit0);
  // sleeping with both power bits low leaves only the Y- switch closed
  wire sleep_yn = between & (pd == 2'b00);

  assign DRV_X_POS      = drv_on & pat[3];
  assign DRV_X_NEG      = drv_on & pat[2];
  assign DRV_Y_POS      = drv_on & pat[1];
  assign DRV_Y_NEG      = (drv_on & pat[0]) | sleep_yn;
  assign MUX_SEL        = acq ? acq_ch_reg : ctl_ch;
  assign REF_DIFF_SEL   = ~ctl_reg.reference_kind_select;
  assign SAMPLE_HOLD    = conv_on & ~acq;
  // bias currents only for the three acquisition clocks to save power
  assign TEMP_BIAS_BASE = acq & (acq_ch_reg == `TSQ_CH_TEMP0);
  assign TEMP_BIAS_X91  = acq & (acq_ch_reg == `TSQ_CH_TEMP1);
  assign BAT_DIV_EN     = acq & (acq_ch_reg == `TSQ_CH_BAT);
  assign ADC_POWER_ON   = acq | conv_on | ctl_reg.power_ctl_bit0;
  assign REF_POWER_ON   = ctl_reg.power_ctl_bit1;
endmodule

// [inc/tsq_cfg.svh]
// constants of the touch converter serial sequencer and its host
// Overview of operation
// - eight clocks per transfer, twenty-four per conversion
// - control byte enters during first eight clocks
// - enough control bits received starts acquisition, drivers
// - three acquisition clocks, then hold and convert
// - single-ended reference: drivers off at hold
// - conversion spans twelve clocks after acquisition
// - ratiometric: drivers stay on, thirteenth clock
// - three trailing clocks, output low, ignored
// - halted clock keeps state, stable acquisition
// - power bit0 high keeps drivers on between
// - fifteen clock overlapped conversions supported
// - channel 000 reads diode at base current
// - channel 111 biases diode at 91 times
// - diode bias only during temperature acquisition
// - battery divider only while sampling channel 010
// - host prefers eight-bit mode for pressure
// - start bit then fields, MSB first
// - resolution bit low twelve, high eight bits
// - power bits 00: sleep between, Y- on
`ifndef TSQ_CFG_SVH
`define TSQ_CFG_SVH
`define TSQ_BYTE_CLKS    4'h8
`define TSQ_CONV_CLKS    5'h18
`define TSQ_ACQ_EDGE     4'h5
`define TSQ_RES_HI       4'hC
`define TSQ_RES_LO       4'h8
`define TSQ_CH_TEMP0     3'h0
`define TSQ_CH_BAT       3'h2
`define TSQ_CH_TEMP1     3'h7
`define TSQ_RAW_FIRST    5'h09
`define TSQ_STRETCH_CLK  5'h07
`define TSQ_OFS_CTRL     8'h00
`define TSQ_OFS_STATUS   8'h04
`define TSQ_OFS_RESULT   8'h08
`define TSQ_OFS_TIMING   8'h0C
`define TSQ_CTRL_GO      8
`define TSQ_ST_ACTIVE    0
`define TSQ_ST_DONE      1
`define TSQ_ST_BUSY      2
`define TSQ_HALF_RST     8'h04
`define TSQ_STRETCH_RST  8'h00
`endif

// [inc/tsq_pkg.sv]
// types of the touch converter serial sequencer
package tsq_pkg;
  typedef logic [2:0] tsq_chan_t;
  typedef struct packed {
    logic channel_select_bit2;
    logic channel_select_bit1;
    logic channel_select_bit0;
    logic mode8;
    logic reference_kind_select;
    logic power_ctl_bit1;
    logic power_ctl_bit0;
  } tsq_ctl_t;
  typedef enum logic [2:0] {RX_HUNT = 3'b001, RX_CFG = 3'b010, RX_ACQ = 3'b100} tsq_rx_st_t;
  typedef enum logic [1:0] {CV_IDLE = 2'b01, CV_RUN = 2'b10} tsq_cv_st_t;
  typedef enum logic [2:0] {HS_IDLE = 3'b001, HS_LOW = 3'b010, HS_HIGH = 3'b100} tsq_hs_st_t;
endpackage

// [inc/tsq_if.sv]
// serial link between the host port and the converter
`timescale 1ns/1ns
interface tsq_if;
  logic serial_clock_in;
  logic cs_b;
  logic din;
  logic dout;
  logic dout_oe;
  logic busy;
  logic busy_oe;
  modport dev (input serial_clock_in, cs_b, din, output dout, dout_oe, busy, busy_oe);
  modport host (output serial_clock_in, cs_b, din, input dout, dout_oe, busy, busy_oe);
endinterface

// [rtl/tsq_edge_sync.sv]
// two flip-flop synchroniser with edge detect
`timescale 1ns/1ns
module tsq_edge_sync (
  input  wire logic CLK,
  input  wire logic RST_B,
  input  wire logic ASYNC_IN,
  output logic      LEVEL,
  output logic      RISE,
  output logic      FALL
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // first stage feeds only the second stage
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= ASYNC_IN;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign LEVEL = sync_reg;
  assign RISE  = sync_reg & ~last_reg;
  assign FALL  = ~sync_reg & last_reg;
endmodule

// [rtl/tsq_host.sv]
// host end: APB controlled serial port that runs one 24 clock conversion
`timescale 1ns/1ns
`include "tsq_cfg.svh"
module tsq_host (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  tsq_if.host              LINK
);
  import tsq_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic dout_s;
  logic busy_s;
  tsq_edge_sync u_dout (.CLK(CLK), .RST_B(RST_B), .ASYNC_IN(LINK.dout),
                        .LEVEL(dout_s), .RISE(), .FALL());
  tsq_edge_sync u_busy (.CLK(CLK), .RST_B(RST_B), .ASYNC_IN(LINK.busy),
                        .LEVEL(busy_s), .RISE(), .FALL());

  ////////////////////////////////////////////////////////////////////////////
  // register slave, zero wait states

  logic [7:0]  ctrl_reg;
  logic [7:0]  half_reg;
  logic [7:0]  stretch_reg;
  logic        done_reg;
  logic [15:0] result_reg;
  logic [31:0] rdata_reg;
  tsq_hs_st_t  hs_reg;

  wire mapped = hit(PADDR, `TSQ_OFS_CTRL) | hit(PADDR, `TSQ_OFS_STATUS)
              | hit(PADDR, `TSQ_OFS_RESULT) | hit(PADDR, `TSQ_OFS_TIMING);
  wire wr      = PSEL & PENABLE & PWRITE & mapped;
  wire active  = (hs_reg != HS_IDLE);
  // a start while a conversion runs is dropped
  wire go      = wr & hit(PADDR, `TSQ_OFS_CTRL) & PWDATA[`TSQ_CTRL_GO] & ~active;
  wire [31:0] rd_mux = hit(PADDR, `TSQ_OFS_CTRL) ? {24'h000000, ctrl_reg} :
                       hit(PADDR, `TSQ_OFS_STATUS) ? {29'h0000000, busy_s, done_reg, active} :
                       hit(PADDR, `TSQ_OFS_RESULT) ? {16'h0000, result_reg} :
                       hit(PADDR, `TSQ_OFS_TIMING) ? {16'h0000, stretch_reg, half_reg} : 32'h00000000;
  wire done_set;
  wire done_clr = wr & hit(PADDR, `TSQ_OFS_STATUS) & PWDATA[`TSQ_ST_DONE];

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg    <= 8'h00;
      half_reg    <= `TSQ_HALF_RST;
      stretch_reg <= `TSQ_STRETCH_RST;
      done_reg    <= 1'b0;
      rdata_reg   <= 32'h00000000;
    end else begin
      if (PSEL && !PENABLE) rdata_reg <= rd_mux;
      if (wr && hit(PADDR, `TSQ_OFS_CTRL) && !active) ctrl_reg <= PWDATA[7:0];
      if (wr && hit(PADDR, `TSQ_OFS_TIMING)) begin
        half_reg    <= PWDATA[7:0];
        stretch_reg <= PWDATA[15:8];
      end
      done_reg <= done_set | (done_reg & ~done_clr); // set beats clear
    end
  end

  assign PRDATA  = rdata_reg;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // serial clock divider and shifter

  logic [4:0]  clk_no_reg;
  logic [8:0]  tmr_reg;
  logic [15:0] raw_reg;
  logic        sclk_reg;
  logic        cs_b_reg;
  logic        din_reg;

  wire expire = (tmr_reg <= 9'h001);
  assign done_set = (hs_reg == HS_LOW) & expire & (clk_no_reg == `TSQ_CONV_CLKS);
  // longer low phase before the eighth rise lets the panel settle
  wire [8:0] low_len = {1'b0, half_reg}
                     + ((clk_no_reg == `TSQ_STRETCH_CLK) ? {1'b0, stretch_reg} : 9'h000);
  wire [2:0] bit_sel = 3'h7 - clk_no_reg[2:0];

  // din changes on falling edges, dout is read at the end of each high phase from the ninth clock on
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hs_reg     <= HS_IDLE;
      clk_no_reg <= 5'h00;
      tmr_reg    <= 9'h000;
      raw_reg    <= 16'h0000;
      result_reg <= 16'h0000;
      sclk_reg   <= 1'b0;
      cs_b_reg   <= 1'b1;
      din_reg    <= 1'b0;
    end else begin
      case (hs_reg)
        HS_IDLE: begin
          if (go) begin
            hs_reg     <= HS_LOW;
            cs_b_reg   <= 1'b0;
            // ctrl_reg only takes the byte at this edge, so the start bit comes straight from the bus
            din_reg    <= PWDATA[7];
            clk_no_reg <= 5'h00;
            tmr_reg    <= {1'b0, half_reg};
          end
        end
        HS_LOW: begin
          tmr_reg <= tmr_reg - 9'h001;
          if (expire) begin
            if (clk_no_reg == `TSQ_CONV_CLKS) begin
              hs_reg     <= HS_IDLE;
              cs_b_reg   <= 1'b1;
              result_reg <= raw_reg;
            end else begin
              hs_reg     <= HS_HIGH;
              sclk_reg   <= 1'b1;
              clk_no_reg <= clk_no_reg + 5'h01;
              tmr_reg    <= {1'b0, half_reg};
            end
          end
        end
        HS_HIGH: begin
          tmr_reg <= tmr_reg - 9'h001;
          if (expire) begin
            hs_reg   <= HS_LOW;
            sclk_reg <= 1'b0;
            tmr_reg  <= low_len;
            // after the byte the line stays low so no start is seen
            din_reg  <= (clk_no_reg < 5'h08) ? ctrl_reg[bit_sel] : 1'b0;
            if (clk_no_reg >= `TSQ_RAW_FIRST) raw_reg <= {raw_reg[14:0], dout_s};
          end
        end
        default: hs_reg <= HS_IDLE;
      endcase
    end
  end

  assign LINK.serial_clock_in = sclk_reg;
  assign LINK.cs_b            = cs_b_reg;
  assign LINK.din             = din_reg;
endmodule

// [test/tsq_assertions.sv]
// link protocol assertions between the host end and the converter end
`timescale 1ns/1ns
module tsq_assertions (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic serial_clock_in,
  input wire logic cs_b,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic busy,
  input wire logic busy_oe
);
  logic       sclk_q;
  logic       sclk_rise;
  logic [4:0] rise_cnt;
  logic [7:0] ctl_seen;
  logic [4:0] busy_end;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  ////////////////////////////////////////////////////////////////////////////////
  // raw serial clock edges, counted per frame; cleared while deselected
  assign sclk_rise = serial_clock_in & ~sclk_q;
  // busy must drop on the falling edge after the last result bit
  assign busy_end  = 5'h08 + (ctl_seen[3] ? 5'h08 : 5'h0C) + {4'h0, ~ctl_seen[2]};

  // edge history of the serial clock
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_clock_in;
    end
  end

  // frame clock count, kept through the deselect edge for the length check
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rise_cnt <= 5'h00;
    end else if (cs_b) begin
      rise_cnt <= 5'h00;
    end else if (sclk_rise) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  // control byte as seen on the wire, msb first
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_seen <= 8'h00;
    end else if (sclk_rise && !cs_b && rise_cnt < 5'h08) begin
      ctl_seen <= {ctl_seen[6:0], din};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_idle_clk_low: assert property (cs_b |-> !serial_clock_in)
    else $error("serial clock high while deselected");
  chk_start_first: assert property ($fell(cs_b) |-> din == 1'b1)
    else $error("frame does not open with the start bit");
  chk_oe_on_select: assert property ($fell(cs_b) |-> ##[1:4] dout_oe)
    else $error("outputs not enabled after select");
  chk_oe_off_deselect: assert property ($rose(cs_b) |-> ##[1:4] !dout_oe)
    else $error("outputs still enabled after deselect");
  chk_busy_oe_pair: assert property (busy_oe == dout_oe)
    else $error("busy and data enables differ");
  chk_no_busy_byte: assert property ((!cs_b && rise_cnt < 5'h08) |-> !busy)
    else $error("busy during the control byte");
  chk_busy_byte_end: assert property ($rose(busy) |-> rise_cnt == 5'h08)
    else $error("busy did not rise at the eighth clock");
  chk_busy_hold: assert property ($rose(busy) |-> busy [*8])
    else $error("busy pulse too short");
  chk_busy_release: assert property (($fell(busy) && !cs_b) |-> rise_cnt == busy_end)
    else $error("busy released at the wrong clock");
  chk_tail_low: assert property ((!cs_b && rise_cnt > 5'h08 && !busy) |-> dout == 1'b0)
    else $error("data output not low in trailing clocks");
  chk_dout_clk_low: assert property ((!cs_b && $changed(dout)) |-> !serial_clock_in)
    else $error("data output changed while serial clock high");
  chk_frame_len: assert property ($rose(cs_b) |-> rise_cnt == 5'h18)
    else $error("frame did not carry twenty-four clocks");
endmodule

// [test/touch_adc_serial_sequencer_tb.sv]
// self-checking bench: APB host end driving the converter end over the serial link
`timescale 1ns/1ns
`include "tsq_cfg.svh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module touch_adc_serial_sequencer_tb;
  import tsq_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [11:0] sample_data;
  logic        drv_xp, drv_xn, drv_yp, drv_yn, ref_diff, s_hold;
  logic        bias_base, bias_x91, bat_div, adc_on, ref_on, e;
  tsq_chan_t   mux_sel;
  logic [6:0]  seen;
  int          n_mismatch, cmp_count;
  // the last entry is a pressure read, done in eight-bit mode since precision is not needed there
  logic [7:0]  cbs [7] = '{8'h94, 8'h87, 8'hFC, 8'hA4, 8'h91, 8'hD8, 8'hBC};
  logic [11:0] smps [7] = '{12'hA5C, 12'h5A3, 12'hC3F, 12'h812, 12'h9E7, 12'h6B1, 12'h3D4};

  tsq_if link ();
  tsq_host i_tsq_host (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  tsq_conv_dev i_tsq_conv_dev (.CLK(clk), .RST_B(rst_b), .LINK(link), .SAMPLE_DATA(sample_data),
    .DRV_X_POS(drv_xp), .DRV_X_NEG(drv_xn), .DRV_Y_POS(drv_yp), .DRV_Y_NEG(drv_yn), .MUX_SEL(mux_sel),
    .REF_DIFF_SEL(ref_diff), .SAMPLE_HOLD(s_hold), .TEMP_BIAS_BASE(bias_base), .TEMP_BIAS_X91(bias_x91),
    .BAT_DIV_EN(bat_div), .ADC_POWER_ON(adc_on), .REF_POWER_ON(ref_on));
  tsq_assertions u_chk (.CLK(clk), .RST_B(rst_b), .serial_clock_in(link.serial_clock_in), .cs_b(link.cs_b),
    .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe), .busy(link.busy), .busy_oe(link.busy_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // switch activity per conversion, sampled mid-cycle so it never races the edge
  // bit 5: X+, X- or Y+ drivers while selected and not converting; bit 6: hold differs from busy
  always @(negedge clk) begin
    seen = seen | {s_hold ^ link.busy,
                   (drv_xp | drv_xn | drv_yp) & ~link.busy & ~link.cs_b,
                   (bias_base | bias_x91 | bat_div) & (link.busy | link.cs_b),
                   (drv_xp | drv_xn | drv_yp | drv_yn) & link.busy, bat_div, bias_x91, bias_base};
  end

  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one APB transfer: setup, access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      n_mismatch++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, ex, r)
  endtask

  // one 24 clock conversion; a second start while active must be dropped
  task automatic conv(input logic [7:0] cb, input logic [11:0] smp);
    logic [15:0] ex;
    int n;
    ex = cb[3] ? {smp[11:4], 8'h00} : {smp, 4'h0};
    if (!cb[2]) ex = ex >> 1;
    sample_data <= smp;
    seen = 7'h00;
    apb(1'b1, `TSQ_OFS_CTRL, {23'h0, 1'b1, cb}, r, e);
    apb(1'b1, `TSQ_OFS_CTRL, 32'h0000_01F0, r, e);
    n = 0;
    r = 32'h0;
    while (r[`TSQ_ST_DONE] !== 1'b1 && n < 400) begin
      apb(1'b0, `TSQ_OFS_STATUS, 32'h0, r, e);
      n++;
    end
    if (n >= 400) begin
      n_mismatch++;
      end_sim();
    end
    `CHK("status_done", 32'h2, r)
    rd_chk(`TSQ_OFS_RESULT, {16'h0, ex}, "result");
    rd_chk(`TSQ_OFS_CTRL, {24'h0, cb}, "ctrl");
    `CHK("bias_base", cb[6:4] == `TSQ_CH_TEMP0, seen[0])
    `CHK("bias_x91", cb[6:4] == `TSQ_CH_TEMP1, seen[1])
    `CHK("bat_div", cb[6:4] == `TSQ_CH_BAT, seen[2])
    `CHK("drv_conv", ~cb[2], seen[3])
    `CHK("bias_outside", 1'b0, seen[4])
    `CHK("drv_acq", cb[6:4] inside {3'h1, 3'h3, 3'h4, 3'h5}, seen[5])
    `CHK("hold_busy", 1'b0, seen[6])
    `CHK("mux_sel", cb[6:4], mux_sel)
    `CHK("ref_diff", ~cb[2], ref_diff)
    `CHK("ref_on", cb[1], ref_on)
    if (cb[1:0] == 2'b00) `CHK("drv_sleep", 5'h01, {adc_on, drv_xp, drv_xn, drv_yp, drv_yn})
    if (cb[0]) `CHK("adc_on", 1'b1, adc_on)
    if (cb[0] && !cb[2]) `CHK("drv_kept", 2'b11, {drv_yp, drv_yn})
    apb(1'b1, `TSQ_OFS_STATUS, 32'h2, r, e);
    rd_chk(`TSQ_OFS_STATUS, 32'h0, "status_clr");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, unmapped access, then the conversion table
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_data = 12'h000;
    seen = 7'h00;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    `CHK("drv_rst", 5'h01, {adc_on, drv_xp, drv_xn, drv_yp, drv_yn})
    rd_chk(`TSQ_OFS_STATUS, 32'h0, "status_rst");
    rd_chk(`TSQ_OFS_TIMING, 32'h4, "timing_rst");
    rd_chk(`TSQ_OFS_CTRL, 32'h0, "ctrl_rst");
    rd_chk(`TSQ_OFS_RESULT, 32'h0, "result_rst");
    apb(1'b0, 8'h10, 32'h0, r, e);
    `CHK("unmapped_rd", 33'h1_0000_0000, {e, r})
    apb(1'b1, 8'h14, 32'hFFFF_FFFF, r, e);
    `CHK("unmapped_wr", 1'b1, e)
    apb(1'b1, `TSQ_OFS_TIMING, 32'hFFFF_FF08, r, e);
    rd_chk(`TSQ_OFS_TIMING, 32'h0000_FF08, "timing_wr");
    // the second case stretches acquisition to show a slowed clock changes nothing
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, `TSQ_OFS_TIMING, {16'h0, (i == 1) ? 8'h30 : 8'h00, 8'h08}, r, e);
      conv(cbs[i], smps[i]);
    end
    end_sim();
  end
endmodule
